// ===== design/adcrd_readout.sv
// Conversion sequencing and parallel result readout of the ADC
`timescale 1ns/1ns
`default_nettype none
module adcrd_readout import adcrd_pkg::*; #(
    parameter bit BIPOLAR = 1'b1
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              sampleTrigger,
    input  wire logic              chipSelectN,
    input  wire logic              fetchStrobeN,
    input  wire logic              busStoreStrobeN,
    input  wire logic              clockSourceSelect,
    input  wire logic              extConvClk,
    input  wire logic [7:0]        dataIn,
    input  wire logic [DATA_W-1:0] coreCode,
    output logic [DATA_W-1:0]      dataOut,
    output logic                   dataOe,
    output logic                   resultReadyN,
    output logic                   finalResultN,
    output logic [2:0]             coreChan
);
    // ==========================================================
    // Pin synchronisers; stage A is read only by stage B
    logic [5:0] pinA_r, pinB_r, pinC_r;
    logic [7:0] dinA_r, dinB_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            // Idle levels, trigger high, so release makes no false edge
            pinA_r <= 6'h2f;
            pinB_r <= 6'h2f;
            pinC_r <= 6'h2f;
            dinA_r <= 8'h00;
            dinB_r <= 8'h00;
        end else begin
            pinA_r <= {clockSourceSelect, extConvClk, busStoreStrobeN,
                       fetchStrobeN, chipSelectN, sampleTrigger};
            pinB_r <= pinA_r;
            pinC_r <= pinB_r;
            dinA_r <= dataIn;
            dinB_r <= dinA_r;
        end
    end

    logic trigRise, trigFall, csS, rdS, rdRise, wrRise, eclkRise, selS;
    assign trigRise = pinB_r[0] && !pinC_r[0];
    assign trigFall = !pinB_r[0] && pinC_r[0];
    assign csS      = pinB_r[1];
    assign rdS      = pinB_r[2];
    assign rdRise   = pinB_r[2] && !pinC_r[2];
    assign wrRise   = pinB_r[3] && !pinC_r[3];
    assign eclkRise = pinB_r[4] && !pinC_r[4];
    assign selS     = pinB_r[5];

    // ==========================================================
    // Sequencer state
    adcrd_state_t state_r, state_nxt;
    logic [3:0]   divCnt_r, divCnt_nxt;
    logic [5:0]   tickCnt_r, tickCnt_nxt, dueCnt_r, dueCnt_nxt;
    logic [3:0]   chan_r, chan_nxt, nextChan, firstChan;
    logic [7:0]   actMask_r, actMask_nxt, cfg_r, cfg_nxt;
    logic         readyN_r, readyN_nxt, finalN_r, finalN_nxt;
    logic         intTick, tick, pushEv, fifoInReady;
    logic [DATA_W-1:0] pushData;

    // Internal clock is a divided enable; external one an edge
    assign intTick   = (divCnt_r == 4'(INT_DIV - 1));
    assign tick      = selS ? intTick : eclkRise;
    assign nextChan  = adcrd_next(actMask_r, chan_r + 4'h1);
    assign firstChan = adcrd_next(cfg_r, 4'h0);
    // A full FIFO stalls the result, so no result is ever dropped
    assign pushEv    = (state_r == ST_CONV) && (tickCnt_r == dueCnt_r)
                       && fifoInReady && !chan_r[3];
    assign pushData  = BIPOLAR ? (coreCode ^ BIPOLAR_FLIP) : coreCode;

    // Next state of the sequencer
    always_comb begin
        state_nxt   = state_r;
        divCnt_nxt  = (intTick || trigRise) ? 4'h0 : divCnt_r + 4'h1;
        tickCnt_nxt = tickCnt_r;
        dueCnt_nxt  = dueCnt_r;
        chan_nxt    = chan_r;
        actMask_nxt = actMask_r;
        cfg_nxt     = cfg_r;
        readyN_nxt  = readyN_r;
        finalN_nxt  = finalN_r;
        // capture enable byte on store edge
        if (wrRise && !pinC_r[1]) begin
            cfg_nxt = dinB_r;
        end
        // Ready pulse lasts until the next conversion tick
        if (tick) begin
            readyN_nxt = 1'b1;
        end
        case (state_r)
            ST_IDLE, ST_DONE: begin
                if (trigRise) begin
                    actMask_nxt = cfg_r;
                    chan_nxt    = firstChan;
                    tickCnt_nxt = 6'h00;
                    dueCnt_nxt  = FIRST_TICK;
                    finalN_nxt  = firstChan[3] ? 1'b0 : 1'b1;
                    readyN_nxt  = 1'b1;
                    state_nxt   = firstChan[3] ? ST_DONE : ST_CONV;
                end
            end
            ST_CONV: begin
                // count ticks toward each due point
                if (tick && tickCnt_r != dueCnt_r) begin
                    tickCnt_nxt = tickCnt_r + 6'h01;
                end
                if (pushEv) begin
                    readyN_nxt = 1'b0;
                    dueCnt_nxt = dueCnt_r + STEP_TICK;
                    chan_nxt   = nextChan;
                    if (nextChan[3]) begin
                        // eight channels end on tick 38
                        finalN_nxt = 1'b0;
                        state_nxt  = ST_DONE;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // a low trigger pulse re-arms the sequencer
        if (trigFall) begin
            finalN_nxt = 1'b1;
            readyN_nxt = 1'b1;
            state_nxt  = ST_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            divCnt_r  <= 4'h0;
            tickCnt_r <= 6'h00;
            dueCnt_r  <= FIRST_TICK;
            chan_r    <= NO_CHAN;
            actMask_r <= CFG_RESET;
            cfg_r     <= CFG_RESET;
            readyN_r  <= 1'b1;
            finalN_r  <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            divCnt_r  <= divCnt_nxt;
            tickCnt_r <= tickCnt_nxt;
            dueCnt_r  <= dueCnt_nxt;
            chan_r    <= chan_nxt;
            actMask_r <= actMask_nxt;
            cfg_r     <= cfg_nxt;
            readyN_r  <= readyN_nxt;
            finalN_r  <= finalN_nxt;
        end
    end

    // ==========================================================
    // Result FIFO and bus drive
    logic              fifoOutValid, popEv;
    logic [DATA_W-1:0] fifoOutData, busData_r, busData_nxt;
    logic              busOe_r, busOe_nxt;

    adcrd_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) uFifo (
        .mclk     (mclk),
        .rst      (rst),
        .inValid  (pushEv),
        .inReady  (fifoInReady),
        .inData   (pushData),
        .outValid (fifoOutValid),
        .outReady (popEv),
        .outData  (fifoOutData)
    );

    // read strobe rise moves to next result
    assign popEv = rdRise && busOe_r && fifoOutValid;

    // Bus drives only while both strobes are low, however select is used
    always_comb begin
        // float when either strobe is high
        busOe_nxt   = !rdS && !csS;
        busData_nxt = fifoOutValid ? fifoOutData : '0;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            busOe_r   <= 1'b0;
            busData_r <= '0;
        end else begin
            busOe_r   <= busOe_nxt;
            busData_r <= busData_nxt;
        end
    end

    assign dataOut      = busData_r;
    assign dataOe       = busOe_r;
    assign resultReadyN = readyN_r;
    assign finalResultN = finalN_r;
    assign coreChan     = chan_r[2:0];

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_float;
        (rdS || csS) |=> !dataOe;
    endproperty
    a_float: assert property (p_float) else $error("bus driven while strobe high");

    property p_drive;
        (!rdS && !csS) ##1 (!rdS && !csS) |-> dataOe && (dataOut == $past(busData_nxt));
    endproperty
    a_drive: assert property (p_drive) else $error("bus not showing head result");

    property p_mask;
        $changed(actMask_r) |-> $past(trigRise) && actMask_r == $past(cfg_r);
    endproperty
    a_mask: assert property (p_mask) else $error("enables changed outside start");

    property p_resetCfg;
        $past(rst) |-> cfg_r == CFG_RESET;
    endproperty
    a_resetCfg: assert property (p_resetCfg) else $error("enables not all on after reset");

    property p_first;
        (state_r != ST_CONV) ##1 (state_r == ST_CONV) |-> dueCnt_r == 6'h11;
    endproperty
    a_first: assert property (p_first) else $error("first result not on tick 17");

    property p_step;
        pushEv && !trigFall && !nextChan[3] |=> dueCnt_r == $past(dueCnt_r) + 6'h03;
    endproperty
    a_step: assert property (p_step) else $error("result spacing not three ticks");

    property p_final;
        $fell(finalResultN) |-> $past(trigRise) || $past(pushEv && nextChan[3]);
    endproperty
    a_final: assert property (p_final) else $error("final flag fell early");

    property p_chan;
        pushEv |-> actMask_r[chan_r[2:0]] && tickCnt_r >= 6'h11;
    endproperty
    a_chan: assert property (p_chan) else $error("result for disabled channel");

    property p_ready;
        $fell(resultReadyN) |-> $past(pushEv);
    endproperty
    a_ready: assert property (p_ready) else $error("ready strobe without result");

    property p_code;
        pushEv |-> pushData[13] == (BIPOLAR ? !coreCode[13] : coreCode[13])
                   && pushData[12:0] == coreCode[12:0];
    endproperty
    a_code: assert property (p_code) else $error("result coding wrong");

endmodule : adcrd_readout
`default_nettype wire

// ===== design/adcrd_pkg.sv
// Shared constants, types and helpers of the ADC result readout block
package adcrd_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned DATA_W     = 14;
    localparam int unsigned CHAN_N     = 8;
    localparam int unsigned FIFO_DEPTH = 16;

    // ==========================================================
    // Timing
    localparam int unsigned MCLK_NS    = 8;
    localparam int unsigned INT_CLK_NS = 100;   // Internal conversion clock period
    localparam int unsigned INT_DIV    = INT_CLK_NS / MCLK_NS;
    localparam logic [5:0]  FIRST_TICK = 6'h11; // 17th conversion tick
    localparam logic [5:0]  STEP_TICK  = 6'h03;

    // ==========================================================
    // Reset values and coding
    localparam logic [7:0]  CFG_RESET    = 8'hff;
    localparam logic [13:0] BIPOLAR_FLIP = 14'h2000;
    localparam logic [3:0]  NO_CHAN      = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b10
    } adcrd_state_t;

    // Lowest enabled channel at or above from, NO_CHAN if none
    function automatic logic [3:0] adcrd_next(input logic [7:0] m, input logic [3:0] from);
        logic [3:0] r;
        r = NO_CHAN;
        for (int i = CHAN_N - 1; i >= 0; i--) begin
            if (m[i] && 4'(i) >= from) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : adcrd_next

endpackage : adcrd_pkg

// ===== design/adcrd_fifo.sv
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module adcrd_fifo #(
    parameter int unsigned W     = 14,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          doPush, doPop;

    // Full and empty come straight from the fill count
    assign inReady  = (cnt_r != (AW+1)'(DEPTH));
    assign outValid = (cnt_r != '0);
    assign outData  = mem[rp_r];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    // ==========================================================
    // Pointer and count next state
    always_comb begin
        wp_nxt  = doPush ? wp_r + 1'b1 : wp_r;
        rp_nxt  = doPop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r;
        if (doPush && !doPop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (doPop && !doPush) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset; the count guards stale words
    always_ff @(posedge mclk) begin
        if (doPush) begin
            mem[wp_r] <= inData;
        end
    end

endmodule : adcrd_fifo
`default_nettype wire

// ===== dv/adcrd_host_model.sv
// Host processor model driving the pins of the ADC readout block
`timescale 1ns/1ns
`default_nettype none
module adcrd_host_model import adcrd_pkg::*; (
    input  wire logic              mclk,
    input  wire logic [2:0]        coreChan,
    input  wire logic              dataOe,
    input  wire logic [DATA_W-1:0] dataOut,
    output logic                   sampleTrigger,
    output logic                   chipSelectN,
    output logic                   fetchStrobeN,
    output logic                   busStoreStrobeN,
    output logic                   clockSourceSelect,
    output logic                   extConvClk,
    output logic [7:0]             dataIn,
    output logic [DATA_W-1:0]      coreCode
);
    logic       extRun;
    logic [3:0] phase;

    // ==========================================================
    // Idle levels
    // Trigger high from the start
    initial begin
        sampleTrigger = 1'b1;
        chipSelectN = 1'b1;
        fetchStrobeN = 1'b1;
        busStoreStrobeN = 1'b1;
        clockSourceSelect = 1'b0;
        dataIn = 8'h00;
        extRun = 1'b0;
        phase = 4'h0;
        extConvClk = 1'b0;
    end

    // Core result tags the channel so order errors show
    assign coreCode = {coreChan, 11'h5a5};

    // External clock, 5 high and 5 low; stands low between frames
    always @(posedge mclk) begin
        phase <= extRun ? ((phase == 4'h9) ? 4'h0 : phase + 4'h1) : 4'h0;
        extConvClk <= extRun && (phase < 4'h5);
    end

    // Low pulse re-arms, rise starts; high otherwise
    task automatic trig_pulse();
        @(posedge mclk);
        sampleTrigger <= 1'b0;
        repeat (4) @(posedge mclk);
        sampleTrigger <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : trig_pulse

    // Byte held across the write strobe rise
    task automatic write_en(input logic [7:0] v);
        @(posedge mclk);
        chipSelectN <= 1'b0;
        busStoreStrobeN <= 1'b0;
        dataIn <= v;
        repeat (4) @(posedge mclk);
        busStoreStrobeN <= 1'b1;
        repeat (4) @(posedge mclk);
        chipSelectN <= 1'b1;
        dataIn <= ~v;  // Released lines must not keep the value
    endtask : write_en

    // Select held low, around the strobe, or tied to it
    task automatic read_word(input int mode, output logic [DATA_W-1:0] w, output bit ok);
        ok = 1'b0;
        @(posedge mclk);
        chipSelectN <= 1'b0;
        if (mode == 1) begin
            @(posedge mclk);
        end
        fetchStrobeN <= 1'b0;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge mclk);
            ok = (dataOe === 1'b1);
        end
        w = dataOut;
        fetchStrobeN <= 1'b1;
        if (mode == 1) begin
            @(posedge mclk);
        end
        if (mode != 0) begin
            chipSelectN <= 1'b1;
        end
        repeat (5) @(posedge mclk);
    endtask : read_word
endmodule : adcrd_host_model
`default_nettype wire

// ===== dv/adcrd_readout_tb.sv
// Self-checking testbench of the ADC result readout block
`timescale 1ns/1ns
`default_nettype none
module adcrd_readout_tb import adcrd_pkg::*;;
    logic              mclk;
    logic              rst;
    logic              sampleTrigger, chipSelectN, fetchStrobeN, busStoreStrobeN;
    logic              clockSourceSelect, extConvClk, dataOe, resultReadyN, finalResultN;
    logic              extPrev, rdyPrev;
    logic [7:0]        dataIn;
    logic [2:0]        coreChan;
    logic [DATA_W-1:0] coreCode, dataOut, uniOut;
    int                tickCnt, readyCnt, numErrors, totalChecks;
    int                firstTick, finTick, firstCyc, finCyc, readies;

    // ==========================================================
    // Clock, design and host
    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    adcrd_readout #(.BIPOLAR(1'b1)) dut (.mclk(mclk), .rst(rst), .sampleTrigger(sampleTrigger),
        .chipSelectN(chipSelectN), .fetchStrobeN(fetchStrobeN), .busStoreStrobeN(busStoreStrobeN),
        .clockSourceSelect(clockSourceSelect), .extConvClk(extConvClk), .dataIn(dataIn),
        .coreCode(coreCode), .dataOut(dataOut), .dataOe(dataOe), .resultReadyN(resultReadyN),
        .finalResultN(finalResultN), .coreChan(coreChan));

    // Unipolar twin on the same pins; only its bus value is watched
    adcrd_readout #(.BIPOLAR(1'b0)) uni (.mclk(mclk), .rst(rst), .sampleTrigger(sampleTrigger),
        .chipSelectN(chipSelectN), .fetchStrobeN(fetchStrobeN), .busStoreStrobeN(busStoreStrobeN),
        .clockSourceSelect(clockSourceSelect), .extConvClk(extConvClk), .dataIn(dataIn),
        .coreCode(coreCode), .dataOut(uniOut), .dataOe(), .resultReadyN(),
        .finalResultN(), .coreChan());

    adcrd_host_model host (.mclk(mclk), .coreChan(coreChan), .dataOe(dataOe), .dataOut(dataOut),
        .sampleTrigger(sampleTrigger), .chipSelectN(chipSelectN), .fetchStrobeN(fetchStrobeN),
        .busStoreStrobeN(busStoreStrobeN), .clockSourceSelect(clockSourceSelect),
        .extConvClk(extConvClk), .dataIn(dataIn), .coreCode(coreCode));

    // Counts pin-level ticks and ready falls for the watchers
    always @(posedge mclk) begin
        extPrev <= extConvClk;
        rdyPrev <= resultReadyN;
        if (extConvClk === 1'b1 && extPrev === 1'b0) tickCnt <= tickCnt + 1;
        if (resultReadyN === 1'b0 && rdyPrev === 1'b1) readyCnt <= readyCnt + 1;
    end

    // ==========================================================
    // Compare and report
    task automatic chk_word(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        totalChecks++;
        if (g !== e) begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic e, input logic g);
        totalChecks++;
        if (g !== e) begin
            numErrors++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit

    task automatic chk_num(input string what, input int e, input int g);
        totalChecks++;
        if (g != e) begin
            numErrors++;
            $display("wrong value %s expected %0d seen %0d", what, e, g);
        end
    endtask : chk_num

    task automatic reportAndStop();
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : reportAndStop

    // Two's complement is offset binary with the sign bit turned over
    function automatic logic [DATA_W-1:0] exp_word(input logic [2:0] ch);
        return {ch, 11'h5a5} ^ BIPOLAR_FLIP;
    endfunction : exp_word

    // ==========================================================
    // Shared helpers
    // Follows one conversion to its final flag, bounded
    task automatic watch_conv();
        int t0;
        int r0;
        t0 = tickCnt;
        r0 = readyCnt;
        firstTick = -1;
        for (int n = 0; n < 3000; n++) begin
            @(posedge mclk);
            if (firstTick < 0 && resultReadyN === 1'b0) begin
                firstTick = tickCnt - t0;
                firstCyc = n;
            end
            if (finalResultN === 1'b0) begin
                finTick = tickCnt - t0;
                finCyc = n;
                @(posedge mclk);
                readies = readyCnt - r0;
                host.extRun <= 1'b0;
                return;
            end
        end
        numErrors++;
        reportAndStop();
    endtask : watch_conv

    // Reads the enabled channels in order, cycling the select usages
    task automatic drain(input logic [7:0] mask);
        logic [DATA_W-1:0] w;
        bit                ok;
        int                k;
        k = 0;
        for (int ch = 0; ch < CHAN_N; ch++) begin
            if (mask[ch]) begin
                chk_word("unipolar head", {3'(ch), 11'h5a5}, uniOut);
                host.read_word(k % 3, w, ok);
                chk_bit("read answered", 1'b1, ok);
                chk_word("result", exp_word(3'(ch)), w);
                chk_bit("bus released", 1'b0, dataOe);
                k++;
            end
        end
    endtask : drain

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk_bit("bus enable", 1'b0, dataOe);
        chk_bit("ready", 1'b1, resultReadyN);
        chk_bit("final", 1'b1, finalResultN);
        chk_word("bus value", 14'h0000, dataOut);
    endtask : t_reset

    // All channels by default; a mid-run write must wait for the next start
    task automatic t_ext_all();
        host.trig_pulse();
        host.write_en(8'h82);
        host.extRun <= 1'b1;
        watch_conv();
        chk_num("first tick", 17, firstTick);
        chk_num("final tick", 38, finTick);
        chk_num("ready pulses", 8, readies);
        drain(8'hff);
    endtask : t_ext_all

    task automatic t_ext_two();
        logic [DATA_W-1:0] w;
        bit                ok;
        host.trig_pulse();
        host.extRun <= 1'b1;
        watch_conv();
        chk_num("first tick", 17, firstTick);
        chk_num("final tick", 20, finTick);
        chk_num("ready pulses", 2, readies);
        drain(8'h82);
        host.read_word(2, w, ok);
        chk_word("empty read", 14'h0000, w);
    endtask : t_ext_two

    task automatic t_int_two();
        host.clockSourceSelect <= 1'b1;
        host.trig_pulse();
        watch_conv();
        chk_num("result gap", 3 * INT_DIV, finCyc - firstCyc);
        chk_bit("first in window", 1'b1,
                (firstCyc + 5 >= 17 * INT_DIV) && (firstCyc + 5 <= 17 * INT_DIV + 12));
        chk_num("ready pulses", 2, readies);
        drain(8'h82);
    endtask : t_int_two

    // Main sequence
    initial begin
        rst = 1'b1;
        tickCnt = 0;
        readyCnt = 0;
        numErrors = 0;
        totalChecks = 0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        // Over twenty clocks with trigger high before the first start
        host.extRun <= 1'b1;
        repeat (260) @(posedge mclk);
        host.extRun <= 1'b0;
        repeat (4) @(posedge mclk);
        t_ext_all();
        t_ext_two();
        t_int_two();
        reportAndStop();
    end
endmodule : adcrd_readout_tb
`default_nettype wire
